// *** src/smbsi_slave.sv ***
`timescale 1ns/1ps
`include "smbsi_params.svh"
// Overview of operation
// - START is SDA falling while SCL high; it begins an addressed transfer.
// - STOP is SDA rising while SCL high; it ends the transfer.
// - First byte after START is seven address bits plus direction bit.
// - Own address is 1001100b, or 1001101b in the alternate variant.
// - Device acknowledges its address by holding SDA low on ninth clock.
// - Byte is eight clocks plus ack; SDA changes only while SCL low.
// - Idle bus has SDA and SCL high; device drives neither line then.
// - Master sets byte count; the receiving side acknowledges each byte.
// - Master ends a read with not-acknowledge; device stops driving data.
// - First written byte after address loads the pointer; later bytes hit register.
// - Reads return the pointed register; pointer persists until next write.
// - Multi-byte reads send high byte then low byte, each MSB first.
// - With timeout enabled, a line low 30 ms in a frame resets interface.
// - Timeout enable comes out of reset set.
// - Master code 00001XXX is not acknowledged but selects high-speed mode.
// - High-speed mode lasts until STOP, then normal filters return.
// - General call 00h then 06h pulses soft reset and reloads pointer 00h and timeout enable set.
// - Other second bytes after general call are ignored without response.
// - Any data written with pointer FCh triggers the same soft reset.
// - Alert response command with alert active is acknowledged; own address returned.
// - Eighth returned bit is high for high-limit cause, low for low-limit.
// - Arbitration winner clears its alert at completion; loser keeps it.

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module smbsi_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta <= '1;
            q_out <= '1;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end

endmodule

// ----------------------------------------
// Link side, clocked by SCL
// ----------------------------------------
module smbsi_link
    import smbsi_pkg::*;
(
    // Clock and reset
    input wire logic scl_clk_in,
    input wire logic reset_in,
    // Bus data
    input wire logic sda_in,
    output smbsi_link_t link_out
);

    // Sample on the rising edge, where SDA is stable
    always_ff @(posedge scl_clk_in or posedge reset_in) begin
        if (reset_in) begin
            link_out <= '1;
        end else begin
            link_out.tog <= ~link_out.tog;
            link_out.sda <= sda_in;
        end
    end

endmodule

// ----------------------------------------
// Slave protocol engine
// ----------------------------------------
module smbsi_slave
    import smbsi_pkg::*;
#(
    parameter int TIMEOUT_CYC = `SMBSI_TIMEOUT_CYC,
    parameter bit ALT_ADDR = 1'b0
) (
    // Clocks and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic scl_clk_in,
    // Bus pins
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Register bank
    output logic [7:0] reg_ptr_out,
    output smbsi_wr_t wr_out,
    output logic wr_stb_out,
    output logic rd_stb_out,
    output logic rd_idx_out,
    input wire logic [7:0] rd_data_in,
    // Alert, reset and mode
    input wire logic alert_in,
    input wire logic alert_high_in,
    output logic alert_clr_out,
    output logic soft_reset_out,
    output logic hs_mode_out,
    output logic timeout_en_out
);

    // ----------------------------------------
    // Crossing and edge detection
    // ----------------------------------------
    smbsi_link_t link;
    logic sda_s;
    logic scl_s;
    logic tog_s;
    logic sda_d;
    logic scl_d;
    logic tog_d;

    smbsi_link u_link (
        .scl_clk_in(scl_clk_in),
        .reset_in(reset_in),
        .sda_in(sda_in),
        .link_out(link)
    );

    smbsi_sync #(
        .W(3)
    ) u_sync (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .d_in({sda_in, scl_clk_in, link.tog}),
        .q_out({sda_s, scl_s, tog_s})
    );

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sda_d <= 1'b1;
            scl_d <= 1'b1;
            tog_d <= 1'b1;
        end else begin
            sda_d <= sda_s;
            scl_d <= scl_s;
            tog_d <= tog_s;
        end
    end

    // Sampled bit is stable a whole SCL period after its toggle lands
    wire start_evt = scl_s & sda_d & ~sda_s;
    wire stop_evt = scl_s & ~sda_d & sda_s;
    wire rise_evt = tog_s ^ tog_d;
    wire fall_evt = scl_d & ~scl_s;
    wire rx_bit = link.sda;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    smbsi_state_t state;
    smbsi_state_t next_state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx_byte;
    logic ack_pend;
    logic next_ack;
    logic txd;
    logic [`SMBSI_TO_W-1:0] to_cnt;

    wire [6:0] own_addr = ALT_ADDR ? `SMBSI_ADDR_ALT : `SMBSI_ADDR_BASE;
    wire [7:0] rx_byte = {shreg[6:0], rx_bit};
    wire byte_done = rise_evt & (bitcnt == `SMBSI_BIT_LAST);
    wire ack_rise = rise_evt & (bitcnt == `SMBSI_BIT_ACK);
    wire hit_own = rx_byte[7:1] == own_addr;
    wire is_gc = rx_byte == `SMBSI_GC_ADDR;
    wire is_ara = (rx_byte == `SMBSI_ARA_CMD) & alert_in;
    wire is_hs = rx_byte[7:3] == `SMBSI_HS_CODE;
    wire tx_state = (state == ST_READ) | (state == ST_ARA);
    wire tx_bit = tx_byte[3'h7 - bitcnt[2:0]];
    wire arb_lost = (state == ST_ARA) & rise_evt & ~bitcnt[3] & tx_bit & ~rx_bit;
    wire rd_nack = (state == ST_READ) & rx_bit;
    wire tx_end = ack_rise & txd & (rd_nack | (state == ST_ARA));
    wire ara_done = ack_rise & txd & (state == ST_ARA);
    wire rd_load = ack_rise & (state == ST_READ) & ~rx_bit;
    wire wr_hit = byte_done & (state == ST_DATA);
    wire swrst_ptr = wr_hit & (reg_ptr_out == `SMBSI_PTR_SWRST);
    wire swrst_gc = byte_done & (state == ST_GC) & (rx_byte == `SMBSI_GC_RESET);
    wire swrst = swrst_ptr | swrst_gc;
    wire to_write = wr_hit & (reg_ptr_out == `SMBSI_PTR_CONALERT);
    wire line_low = ~scl_s | ~sda_s;
    wire to_run = timeout_en_out & (state != ST_IDLE) & line_low;
    wire expire = to_run & (to_cnt == TIMEOUT_CYC[`SMBSI_TO_W-1:0] - 1'b1);

    // ----------------------------------------
    // Transfer state machine
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_ack = ack_pend;
        if (ack_rise) begin
            next_ack = 1'b0;
        end
        if (byte_done) begin
            next_ack = 1'b0;
            case (state)
                ST_ADDR: begin
                    if (is_hs) begin
                        next_state = ST_IGNORE;
                    end else if (hit_own) begin
                        next_ack = 1'b1;
                        next_state = rx_byte[0] ? ST_READ : ST_PTR;
                    end else if (is_gc) begin
                        next_ack = 1'b1;
                        next_state = ST_GC;
                    end else if (is_ara) begin
                        next_ack = 1'b1;
                        next_state = ST_ARA;
                    end else begin
                        next_state = ST_IGNORE;
                    end
                end
                ST_PTR: begin
                    next_ack = 1'b1;
                    next_state = ST_DATA;
                end
                ST_DATA: begin
                    next_ack = 1'b1;
                end
                ST_GC: begin
                    next_ack = swrst_gc;
                    next_state = ST_IGNORE;
                end
                default: begin
                    next_ack = 1'b0;
                end
            endcase
        end
        if (tx_end | arb_lost) begin
            next_state = ST_IGNORE;
        end
        if (start_evt) begin
            next_state = ST_ADDR;
        end
        if (stop_evt | expire) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            ack_pend <= 1'b0;
        end else begin
            state <= next_state;
            ack_pend <= next_ack;
        end
    end

    // ----------------------------------------
    // Bit counter and receive shifter
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bitcnt <= 4'h0;
        end else if (start_evt) begin
            bitcnt <= 4'h0;
        end else if (ack_rise) begin
            bitcnt <= 4'h0;
        end else if (rise_evt) begin
            bitcnt <= bitcnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            shreg <= 8'h00;
        end else if (rise_evt & ~bitcnt[3]) begin
            shreg <= rx_byte;
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_byte <= 8'h00;
        end else if (byte_done & (state == ST_ADDR) & is_ara) begin
            tx_byte <= {own_addr, alert_high_in};
        end else if (rd_load) begin
            tx_byte <= rd_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            txd <= 1'b0;
        end else if (start_evt) begin
            txd <= 1'b0;
        end else if (ack_rise & tx_state) begin
            txd <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_idx_out <= 1'b0;
            rd_stb_out <= 1'b0;
        end else begin
            rd_stb_out <= rd_load;
            if (byte_done & (state == ST_ADDR)) begin
                rd_idx_out <= 1'b0;
            end else if (rd_load) begin
                rd_idx_out <= 1'b1;
            end
        end
    end

    // Drive only after SCL falls; a change while high would be a START or STOP
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sda_oe_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (stop_evt | expire | (next_state == ST_IDLE)) begin
            sda_oe_out <= 1'b0;
        end else if (fall_evt) begin
            if (bitcnt == `SMBSI_BIT_ACK) begin
                sda_oe_out <= ack_pend;
            end else begin
                sda_oe_out <= tx_state & ~tx_bit & ~arb_lost;
            end
        end else if (arb_lost) begin
            sda_oe_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pointer, writes and resets
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_ptr_out <= `SMBSI_PTR_RESET;
        end else if (swrst) begin
            reg_ptr_out <= `SMBSI_PTR_RESET;
        end else if (byte_done & (state == ST_PTR)) begin
            reg_ptr_out <= rx_byte;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_out <= '0;
            wr_stb_out <= 1'b0;
        end else begin
            wr_stb_out <= wr_hit & ~swrst_ptr;
            if (wr_hit) begin
                wr_out <= {reg_ptr_out, rx_byte};
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            soft_reset_out <= 1'b0;
            alert_clr_out <= 1'b0;
        end else begin
            soft_reset_out <= swrst;
            alert_clr_out <= ara_done;
        end
    end

    // ----------------------------------------
    // Speed mode and bus timeout
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hs_mode_out <= 1'b0;
        end else if (stop_evt | expire) begin
            hs_mode_out <= 1'b0;
        end else if (byte_done & (state == ST_ADDR) & is_hs) begin
            hs_mode_out <= 1'b1;
        end
    end

    // Shadow of the enable bit; the bank holds the readable copy
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            timeout_en_out <= `SMBSI_TO_EN_RESET;
        end else if (swrst) begin
            timeout_en_out <= `SMBSI_TO_EN_RESET;
        end else if (to_write) begin
            timeout_en_out <= rx_byte[`SMBSI_TO_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            to_cnt <= '0;
        end else if (to_run & ~expire) begin
            to_cnt <= to_cnt + 1'b1;
        end else begin
            to_cnt <= '0;
        end
    end

endmodule

// *** src/smbsi_params.svh ***
`ifndef SMBSI_PARAMS_SVH
`define SMBSI_PARAMS_SVH
`define SMBSI_ADDR_BASE 7'h4C
`define SMBSI_ADDR_ALT 7'h4D
`define SMBSI_GC_ADDR 8'h00
`define SMBSI_GC_RESET 8'h06
`define SMBSI_ARA_CMD 8'h19
`define SMBSI_HS_CODE 5'h01
`define SMBSI_PTR_SWRST 8'hFC
`define SMBSI_PTR_CONALERT 8'h22
`define SMBSI_TO_EN_BIT 7
`define SMBSI_TO_EN_RESET 1'h1
`define SMBSI_PTR_RESET 8'h00
`define SMBSI_TIMEOUT_MS 30
`define SMBSI_CLK_HZ 40000000
`define SMBSI_TIMEOUT_CYC (`SMBSI_TIMEOUT_MS * (`SMBSI_CLK_HZ / 1000))
`define SMBSI_TO_W 21
`define SMBSI_BIT_LAST 4'h7
`define SMBSI_BIT_ACK 4'h8
`endif

// *** src/smbsi_pkg.sv ***
package smbsi_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_DATA,
        ST_GC,
        ST_READ,
        ST_ARA,
        ST_IGNORE
    } smbsi_state_t;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } smbsi_wr_t;

    typedef struct packed {
        logic tog;
        logic sda;
    } smbsi_link_t;

endpackage

// *** sim/smbsi_slave_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the slave engine
// ----------------------------------------
module smbsi_checker
    import smbsi_pkg::*;
#(
    parameter int TIMEOUT_CYC = 1200000
) (
    // Clocks and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic scl_clk_in,
    // Bus pins
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // Register bank
    input wire logic [7:0] reg_ptr_out,
    input wire smbsi_wr_t wr_out,
    input wire logic wr_stb_out,
    input wire logic rd_stb_out,
    input wire logic rd_idx_out,
    input wire logic [7:0] rd_data_in,
    // Alert, reset and mode
    input wire logic alert_in,
    input wire logic alert_high_in,
    input wire logic alert_clr_out,
    input wire logic soft_reset_out,
    input wire logic hs_mode_out,
    input wire logic timeout_en_out
);
    // Saturating, so a stuck bus never wraps it
    int scl_low;
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            scl_low <= 0;
        end else if (scl_clk_in) begin
            scl_low <= 0;
        end else if (scl_low < TIMEOUT_CYC + 16) begin
            scl_low <= scl_low + 1;
        end
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    sda_drain_a: assert property (!sda_out)
        else $error("sda data level not low");
    reset_state_a: assert property ($fell(reset_in) |-> timeout_en_out && reg_ptr_out == 8'h00)
        else $error("bad state after reset");
    soft_clear_a: assert property (soft_reset_out |-> ##[0:2] (reg_ptr_out == 8'h00 && timeout_en_out))
        else $error("soft reset left state");
    wr_ptr_match_a: assert property (wr_stb_out |-> wr_out.ptr == reg_ptr_out)
        else $error("write not at pointer");
    wr_no_fc_a: assert property (wr_stb_out |-> wr_out.ptr != 8'hFC)
        else $error("reset pointer written to bank");
    rd_idx_step_a: assert property (rd_stb_out |-> ##[0:1] rd_idx_out)
        else $error("read index did not advance");
    oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_clk_in)
        else $error("sda moved with scl high");
    stop_release_a: assert property (scl_clk_in && $rose(sda_in) |-> ##[1:6] (!hs_mode_out && !sda_oe_out))
        else $error("stop did not restore idle");
    timeout_rel_a: assert property (timeout_en_out && scl_low == TIMEOUT_CYC + 8 |-> !sda_oe_out)
        else $error("stuck bus not released");
    alert_clr_a: assert property (alert_clr_out |-> alert_in)
        else $error("alert cleared while inactive");
    cover property (wr_stb_out);
    cover property (alert_clr_out);
    cover property (soft_reset_out);
    cover property (hs_mode_out && sda_oe_out);
endmodule

// *** sim/smbsi_master_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Bus master, own 48 ns link time base
// ----------------------------------------
module smbsi_master_model (
    // Bus pins
    output logic scl_out,
    output logic sda_pull_out,
    input wire logic sda_in
);
    logic link_clk;
    initial begin
        link_clk = 1'b0;
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end
    // Three ticks a phase keeps each SCL phase above 100 ns
    task automatic hold(input int n = 3);
        repeat (n) @(posedge link_clk);
    endtask
    task automatic start_c();
        sda_pull_out <= 1'b0;
        hold();
        scl_out <= 1'b1;
        hold();
        sda_pull_out <= 1'b1;
        hold();
        scl_out <= 1'b0;
        hold();
    endtask
    task automatic stop_c();
        sda_pull_out <= 1'b1;
        hold();
        scl_out <= 1'b1;
        hold();
        sda_pull_out <= 1'b0;
        hold();
    endtask
    // Eight bits MSB first plus ninth; a stall stretches the ninth low phase
    task automatic xfer(input logic [7:0] tx, input logic nine_b, input int stall,
                        output logic [7:0] rx, output logic ack);
        logic [8:0] bits;
        bits = {tx, nine_b};
        for (int i = 8; i >= 0; i--) begin
            sda_pull_out <= !bits[i];
            hold((i == 0) ? 3 + stall : 3);
            scl_out <= 1'b1;
            hold();
            if (i > 0) rx[i-1] = sda_in;
            else ack = !sda_in;
            scl_out <= 1'b0;
            hold();
        end
    endtask
endmodule

// *** sim/tb_smbus_slave_sensor_interface.sv ***
`timescale 1ns/1ps
module tb_smbus_slave_sensor_interface;
    import smbsi_pkg::*;
    localparam int TO_CYC = 400;
    logic sys_clk_in, reset_in, scl, sda_pull, sda_wire, sda_out, sda_oe_out, a;
    logic wr_stb_out, rd_stb_out, rd_idx_out, alert_in, alert_high_in;
    logic alert_clr_out, soft_reset_out, hs_mode_out, timeout_en_out;
    logic [7:0] reg_ptr_out, rd_data_in, p, d, rx;
    logic [31:0] lfsr;
    smbsi_wr_t wr_out, last_wr;
    int errors, n_compared, n_wr, n_rst, n_clr, n;
    function automatic logic [7:0] bank(input logic [7:0] ptr, input logic idx);
        return idx ? ~ptr : ptr ^ 8'h5A;
    endfunction
    function automatic logic [7:0] rnd8();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    // Open-drain wire with pull-up
    assign sda_wire = !sda_pull && !(sda_oe_out && !sda_out);
    assign rd_data_in = bank(reg_ptr_out, rd_idx_out);
    smbsi_master_model m (.scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda_wire));
    smbsi_slave #(.TIMEOUT_CYC(TO_CYC), .ALT_ADDR(1'b0)) DUT (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .scl_clk_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg_ptr_out(reg_ptr_out),
        .wr_out(wr_out), .wr_stb_out(wr_stb_out), .rd_stb_out(rd_stb_out),
        .rd_idx_out(rd_idx_out), .rd_data_in(rd_data_in), .alert_in(alert_in),
        .alert_high_in(alert_high_in), .alert_clr_out(alert_clr_out),
        .soft_reset_out(soft_reset_out), .hs_mode_out(hs_mode_out),
        .timeout_en_out(timeout_en_out));
    always @(posedge sys_clk_in) begin
        if (wr_stb_out === 1'b1) begin
            n_wr++;
            last_wr = wr_out;
        end
        if (soft_reset_out === 1'b1) n_rst++;
        if (alert_clr_out === 1'b1) n_clr++;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic nine_b, input logic exp_ack);
        m.xfer(tx, nine_b, 0, rx, a);
        check(a, exp_ack);
    endtask
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] dat);
        m.start_c();
        byte_io(8'h98, 1'b1, 1'b1);
        byte_io(ptr, 1'b1, 1'b1);
        byte_io(dat, 1'b1, 1'b1);
        m.stop_c();
    endtask
    // Two bytes, master acks the first and nacks the second
    task automatic rd_two(input logic [7:0] ptr);
        m.start_c();
        byte_io(8'h99, 1'b1, 1'b1);
        byte_io(8'hFF, 1'b0, 1'b1);
        check(rx, bank(ptr, 1'b0));
        byte_io(8'hFF, 1'b1, 1'b0);
        check(rx, bank(ptr, 1'b1));
        check(sda_oe_out, 1'b0);
        m.stop_c();
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end
    initial begin
        reset_in = 1'b1;
        alert_in = 1'b0;
        alert_high_in = 1'b0;
        lfsr = 32'h000174A9;
        errors = 0;
        n_compared = 0;
        n_wr = 0;
        n_rst = 0;
        n_clr = 0;
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        check({timeout_en_out, reg_ptr_out}, 16'h0100);
        for (int k = 0; k < 4; k++) begin
            p = (k == 0) ? 8'h00 : rnd8();
            if (p == 8'hFC || p == 8'h22) p = 8'h05;
            d = rnd8();
            wr_reg(p, d);
            check(last_wr, {p, d});
            n = n_wr;
            m.start_c();
            byte_io(8'h98, 1'b1, 1'b1);
            byte_io(p ^ 8'h01, 1'b1, 1'b1);
            check(reg_ptr_out, p ^ 8'h01);
            rd_two(p ^ 8'h01);
            rd_two(p ^ 8'h01);
            check(n_wr - n, 0);
        end
        $display("test write_read done");
        for (int k = 0; k < 6; k++) begin
            p = (k == 0) ? 8'h9A : rnd8();
            if (p[7:1] == 7'h4C || p[7:1] == 7'h00 || p[7:3] == 5'h01 || p[7:1] == 7'h0C) p = 8'hA1;
            m.start_c();
            byte_io(p, 1'b1, 1'b0);
            m.stop_c();
        end
        $display("test foreign done");
        d = rnd8();
        m.start_c();
        byte_io({5'h01, d[2:0]}, 1'b1, 1'b0);
        check(hs_mode_out, 1'b1);
        m.start_c();
        byte_io(8'h98, 1'b1, 1'b1);
        m.stop_c();
        repeat (8) @(posedge sys_clk_in);
        check(hs_mode_out, 1'b0);
        $display("test high_speed done");
        wr_reg(8'h22, 8'h01);
        check(timeout_en_out, 1'b0);
        m.start_c();
        byte_io(8'h00, 1'b1, 1'b1);
        byte_io(8'h07, 1'b1, 1'b0);
        m.stop_c();
        check(n_rst, 0);
        m.start_c();
        byte_io(8'h00, 1'b1, 1'b1);
        byte_io(8'h06, 1'b1, 1'b1);
        m.stop_c();
        check({n_rst[6:0], timeout_en_out, reg_ptr_out}, 16'h0300);
        n = n_wr;
        m.start_c();
        byte_io(8'h98, 1'b1, 1'b1);
        byte_io(8'hFC, 1'b1, 1'b1);
        byte_io(rnd8(), 1'b1, 1'b1);
        m.stop_c();
        check({n_rst[7:0], reg_ptr_out}, 16'h0200);
        check(n_wr - n, 0);
        $display("test soft_reset done");
        // Device drops its ack once SCL is stuck low past the timeout
        m.start_c();
        m.xfer(8'h98, 1'b1, 260, rx, a);
        check(a, 1'b0);
        m.stop_c();
        $display("test timeout done");
        m.start_c();
        byte_io(8'h19, 1'b1, 1'b0);
        m.stop_c();
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk_in);
            alert_in <= 1'b1;
            alert_high_in <= (k != 0);
            m.start_c();
            byte_io(8'h19, 1'b1, 1'b1);
            byte_io((k == 2) ? 8'h7F : 8'hFF, 1'b1, 1'b0);
            if (k < 2) check(rx, {7'h4C, k != 0});
            m.stop_c();
            check(n_clr, (k < 2) ? k + 1 : 2);
            @(posedge sys_clk_in);
            alert_in <= 1'b0;
        end
        $display("test alert done");
        wrap_up();
    end
endmodule
bind smbsi_slave smbsi_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .scl_clk_in(scl_clk_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg_ptr_out(reg_ptr_out), .wr_out(wr_out),
    .wr_stb_out(wr_stb_out), .rd_stb_out(rd_stb_out), .rd_idx_out(rd_idx_out),
    .rd_data_in(rd_data_in), .alert_in(alert_in), .alert_high_in(alert_high_in),
    .alert_clr_out(alert_clr_out), .soft_reset_out(soft_reset_out),
    .hs_mode_out(hs_mode_out), .timeout_en_out(timeout_en_out));
